//--- pkg/modem_cfg.svh
// constants for the radio modem mode controller
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH

// clock and prescaled tick
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_MS 10
`define TICK_CYCLES ((`TICK_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)

// times in milliseconds and their tick counts
`define INACT_MS 60000
`define INACT_TICKS (`INACT_MS / `TICK_PERIOD_MS)
`define GAP_MS 290
`define GAP_TICKS (`GAP_MS / `TICK_PERIOD_MS)
`define NOTUS_MS 200
`define NOTUS_TICKS (`NOTUS_MS / `TICK_PERIOD_MS)
`define FULL_MS 1000
`define FULL_TICKS (`FULL_MS / `TICK_PERIOD_MS)
`define HALF_MS 500
`define HALF_TICKS (`HALF_MS / `TICK_PERIOD_MS)

// transparent block size in characters
`define BLOCK_CHARS 238
// terminate command character, upper case
`define CMD_TERMINATE 8'h54

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CONFIG 8'h08

// control register fields
`define CTRL_FLASH_GO 0
`define CTRL_RESULT_LO 1
`define CTRL_TERMINATE 3

// status register fields
`define STAT_MODE_LO 0
`define STAT_ID_LO 4
`define STAT_STATE 12
`define STAT_RING 13
`define STAT_LAMP 14
`define STAT_TELECOM 15
`define STAT_FLASHING 16

// shipped identities
`define SHIP_ID 8'h01
`define BASE_ID 8'hfe

`endif

//--- pkg/modem_pkg.sv
// types shared by the radio modem mode controller
// assumes modem_cfg.svh for numeric constants
`default_nettype none
package modem_pkg;
	typedef enum logic [2:0] {
		MODE_POWERUP, MODE_WAIT, MODE_LOCAL, MODE_REPEATER, MODE_END, MODE_TRANSPARENT
	} mode_type;
	typedef enum logic [1:0] {
		RESULT_PASS, RESULT_RAM, RESULT_ROM, RESULT_NONE
	} result_type;
endpackage
`default_nettype wire

//--- design/modem_mode_ctrl.sv
// mode controller of a radio-link modem between a serial port and a radio
// assumes radio and serial framing logic on the same clock, switches on pins
`include "modem_cfg.svh"
`default_nettype none

module modem_mode_ctrl #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter bit BASE_UNIT = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// pins
	input wire logic [8:0] configSwitch,
	input wire logic modem_enable_line,
	input wire logic radioCarrier,
	output logic ringLine,
	output logic carrierLamp,
	// radio framing logic
	input wire logic rxNotForUs,
	input wire logic rxBlockValid,
	input wire logic rxSetupMid,
	input wire logic rxSetupEnd,
	input wire logic linkVerified,
	input wire logic rxDataValid,
	input wire logic rxSigOk,
	output logic fwdBlock,
	output logic dropBlock,
	// serial port characters
	input wire logic serRxValid,
	input wire logic [7:0] serRxChar,
	output logic cmdValid,
	output logic [7:0] cmdChar,
	output logic txCharValid,
	output logic [7:0] txChar,
	output logic txBlockClose,
	output logic [2:0] modeOut,
	output logic [7:0] stationId
);

	// ==========================================================
	// helpers
	function automatic logic [12:0] phaseTicks(input logic [1:0] res, input logic [1:0] ph);
		logic [12:0] t;
		t = 13'(`HALF_TICKS);
		if (res == 2'(modem_pkg::RESULT_PASS) || (res == 2'(modem_pkg::RESULT_ROM) && ph == 2'h0))
			t = 13'(`FULL_TICKS);
		return t;
	endfunction

	function automatic logic isUpper(input logic [7:0] c);
		return c >= 8'h41 && c <= 8'h5a;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [10:0] syncA_r, syncB_r, syncC_r, pinFilt_r;
	logic [10:0] pinRaw;

	assign pinRaw = {radioCarrier, modem_enable_line, configSwitch};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncA_r <= 11'h000;
			syncB_r <= 11'h000;
			syncC_r <= 11'h000;
		end else if (clkEn) begin
			syncA_r <= pinRaw;
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	// a bit changes only once the second and third stage agree
	always_ff @(posedge clk) begin
		if (!resetn)
			pinFilt_r <= 11'h000;
		else if (clkEn)
			pinFilt_r <= (pinFilt_r & (syncB_r ^ syncC_r)) | (syncB_r & ~(syncB_r ^ syncC_r));
	end

	logic meHigh, carrierIn;
	assign meHigh = pinFilt_r[9];
	assign carrierIn = pinFilt_r[10];

	// ==========================================================
	// strap capture after reset release
	logic [2:0] settle_r;
	logic strapDone_r, enableState_r;
	logic [7:0] id_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			settle_r <= 3'h0;
			strapDone_r <= 1'b0;
			enableState_r <= 1'b1;
			id_r <= `SHIP_ID;
		end else if (clkEn && !strapDone_r) begin
			settle_r <= settle_r + 3'h1;
			if (settle_r == 3'h5) begin
				strapDone_r <= 1'b1;
				enableState_r <= pinFilt_r[8];
				// all-closed identity switches fall back to the shipped identity, or to the base identity when BASE_UNIT is set
				if (pinFilt_r[7:0] == 8'h00)
					id_r <= BASE_UNIT ? `BASE_ID : `SHIP_ID;
				else
					id_r <= pinFilt_r[7:0];
			end
		end
	end

	assign stationId = id_r;

	// ==========================================================
	// prescaled tick
	logic [31:0] pre_r;
	logic tick;

	assign tick = (pre_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!resetn)
			pre_r <= 32'h0;
		else if (clkEn)
			pre_r <= tick ? 32'h0 : pre_r + 32'h1;
	end

	// ==========================================================
	// register bus
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic flashGo, termReq, telecom;
	logic [1:0] resultSel;
	logic [31:0] statusWord;
	logic [2:0] flashPh_r;
	logic flashing_r;
	modem_pkg::mode_type mode_r;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// telecom mode is signalled by the enable line in either enable-line state
	assign telecom = meHigh;

	assign statusWord = {15'h0000, flashing_r, telecom, carrierLamp, ringLine,
		enableState_r, id_r, 1'b0, 3'(mode_r)};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			hrdata <= 32'h0;
		end else if (clkEn) begin
			if (hready) begin
				wrPend_r <= hsel && htrans[1] && hwrite;
				wrAddr_r <= haddr;
				hrdata <= 32'h0;
				if (hsel && htrans[1] && !hwrite && haddr == `REG_STATUS)
					hrdata <= statusWord;
				if (hsel && htrans[1] && !hwrite && haddr == `REG_CONFIG)
					hrdata <= {23'h0, enableState_r, id_r};
			end
		end
	end

	assign flashGo = wrPend_r && wrAddr_r == `REG_CTRL && hwdata[`CTRL_FLASH_GO];
	assign resultSel = hwdata[`CTRL_RESULT_LO +: 2];
	assign termReq = wrPend_r && wrAddr_r == `REG_CTRL && hwdata[`CTRL_TERMINATE];

	// ==========================================================
	// self-test flash sequencer
	logic [1:0] result_r;
	logic [12:0] flashCnt_r;
	logic flashLamp;

	assign flashLamp = !flashPh_r[0];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flashing_r <= 1'b0;
			result_r <= 2'(modem_pkg::RESULT_NONE);
			flashPh_r <= 3'h0;
			flashCnt_r <= 13'h0;
		end else if (clkEn) begin
			if (flashGo && resultSel != 2'(modem_pkg::RESULT_NONE)) begin
				flashing_r <= 1'b1;
				result_r <= resultSel;
				flashPh_r <= 3'h0;
				flashCnt_r <= 13'h0;
			end else if (flashing_r && tick) begin
				if (flashCnt_r + 13'h1 >= phaseTicks(result_r, flashPh_r[1:0])) begin
					flashCnt_r <= 13'h0;
					if (result_r == 2'(modem_pkg::RESULT_PASS) && flashPh_r == 3'h2)
						flashing_r <= 1'b0;
					else if (result_r == 2'(modem_pkg::RESULT_RAM))
						flashPh_r <= {2'b00, ~flashPh_r[0]};
					else
						flashPh_r <= {1'b0, flashPh_r[1:0] + 2'h1};
				end else
					flashCnt_r <= flashCnt_r + 13'h1;
			end
		end
	end

	// ==========================================================
	// carrier lamp
	logic notUs_r;
	logic [4:0] notUsCnt_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			notUs_r <= 1'b0;
			notUsCnt_r <= 5'h0;
		end else if (clkEn) begin
			if (!carrierIn) begin
				notUs_r <= 1'b0;
				notUsCnt_r <= 5'h0;
			end else begin
				if (rxNotForUs)
					notUs_r <= 1'b1;
				if (tick && notUsCnt_r < 5'(`NOTUS_TICKS))
					notUsCnt_r <= notUsCnt_r + 5'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			carrierLamp <= 1'b0;
		else if (clkEn) begin
			if (flashing_r)
				carrierLamp <= flashLamp;
			else
				carrierLamp <= carrierIn && !(notUs_r && notUsCnt_r >= 5'(`NOTUS_TICKS));
		end
	end

	// ==========================================================
	// inactivity timer
	logic [12:0] inact_r;
	logic expired;

	assign expired = inact_r >= 13'(`INACT_TICKS) && !telecom;

	always_ff @(posedge clk) begin
		if (!resetn)
			inact_r <= 13'h0;
		else if (clkEn) begin
			if (rxBlockValid || mode_r == modem_pkg::MODE_WAIT || mode_r == modem_pkg::MODE_POWERUP)
				inact_r <= 13'h0;
			else if (tick && inact_r < 13'(`INACT_TICKS))
				inact_r <= inact_r + 13'h1;
		end
	end

	// ==========================================================
	// operating mode
	logic localTerm;

	assign localTerm = serRxValid && serRxChar == `CMD_TERMINATE;

	always_ff @(posedge clk) begin
		if (!resetn)
			mode_r <= modem_pkg::MODE_POWERUP;
		else if (clkEn) begin
			case (mode_r)
				modem_pkg::MODE_POWERUP: begin
					if (strapDone_r)
						mode_r <= modem_pkg::MODE_WAIT;
				end
				modem_pkg::MODE_WAIT: begin
					if (rxSetupMid)
						mode_r <= modem_pkg::MODE_REPEATER;
					else if (rxSetupEnd)
						mode_r <= modem_pkg::MODE_END;
					else if (telecom)
						mode_r <= modem_pkg::MODE_LOCAL;
				end
				modem_pkg::MODE_LOCAL: begin
					if (localTerm || termReq)
						mode_r <= modem_pkg::MODE_WAIT;
					else if (linkVerified)
						mode_r <= modem_pkg::MODE_TRANSPARENT;
				end
				modem_pkg::MODE_END: begin
					if (expired)
						mode_r <= modem_pkg::MODE_WAIT;
					else if (meHigh)
						mode_r <= modem_pkg::MODE_TRANSPARENT;
				end
				modem_pkg::MODE_REPEATER, modem_pkg::MODE_TRANSPARENT: begin
					if (expired)
						mode_r <= modem_pkg::MODE_WAIT;
				end
				default: mode_r <= modem_pkg::MODE_WAIT;
			endcase
		end
	end

	assign modeOut = 3'(mode_r);

	// ==========================================================
	// ring line
	always_ff @(posedge clk) begin
		if (!resetn)
			ringLine <= 1'b0;
		else if (clkEn) begin
			if (meHigh)
				ringLine <= 1'b0;
			else if (mode_r == modem_pkg::MODE_WAIT && rxSetupEnd && !rxSetupMid)
				ringLine <= 1'b1;
		end
	end

	// ==========================================================
	// local commands and repeater forwarding
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmdValid <= 1'b0;
			cmdChar <= 8'h00;
			fwdBlock <= 1'b0;
			dropBlock <= 1'b0;
		end else if (clkEn) begin
			// lower case is dropped: commands are upper-case only
			cmdValid <= mode_r == modem_pkg::MODE_LOCAL && serRxValid && isUpper(serRxChar);
			if (serRxValid)
				cmdChar <= serRxChar;
			fwdBlock <= mode_r == modem_pkg::MODE_REPEATER && rxDataValid && rxSigOk;
			dropBlock <= mode_r == modem_pkg::MODE_REPEATER && rxDataValid && !rxSigOk;
		end
	end

	// ==========================================================
	// transparent block packing
	logic [7:0] fill_r;
	logic [4:0] gap_r;
	logic inTransp;

	assign inTransp = mode_r == modem_pkg::MODE_TRANSPARENT;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fill_r <= 8'h00;
			gap_r <= 5'h0;
			txCharValid <= 1'b0;
			txChar <= 8'h00;
			txBlockClose <= 1'b0;
		end else if (clkEn) begin
			txCharValid <= inTransp && serRxValid;
			txBlockClose <= 1'b0;
			if (serRxValid)
				txChar <= serRxChar;
			if (!inTransp) begin
				fill_r <= 8'h00;
				gap_r <= 5'h0;
			end else if (serRxValid) begin
				gap_r <= 5'h0;
				// close coincides with the character that fills the block
				if (fill_r == 8'(`BLOCK_CHARS - 1)) begin
					fill_r <= 8'h00;
					txBlockClose <= 1'b1;
				end else
					fill_r <= fill_r + 8'h1;
			end else if (fill_r != 8'h00 && tick) begin
				if (gap_r + 5'h1 >= 5'(`GAP_TICKS)) begin
					gap_r <= 5'h0;
					fill_r <= 8'h00;
					txBlockClose <= 1'b1;
				end else
					gap_r <= gap_r + 5'h1;
			end
		end
	end

endmodule
`default_nettype wire

//--- tb/modem_mode_ctrl_properties.sv
// port assertions for the modem mode controller
// assumes one clock and the synchronous active-low reset
`default_nettype none
module modem_ctrl_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic modem_enable_line,
	input wire logic rxSetupEnd,
	input wire logic rxDataValid,
	input wire logic rxSigOk,
	input wire logic serRxValid,
	input wire logic [7:0] serRxChar,
	input wire logic ringLine,
	input wire logic fwdBlock,
	input wire logic dropBlock,
	input wire logic txCharValid,
	input wire logic [7:0] txChar,
	input wire logic [2:0] modeOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// properties
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or erred");
	a_end_entry: assert property (
		modeOut == 3'h1 && rxSetupEnd && clkEn |=> modeOut == 3'h4 && ringLine)
		else $error("end mode not entered");
	a_ring_end: assert property ($rose(ringLine) |-> modeOut == 3'h4)
		else $error("ring raised outside end mode");
	a_ring_drop: assert property (ringLine && modem_enable_line |-> ##[1:6] !ringLine)
		else $error("ring held after enable");
	a_fwd_good: assert property (
		modeOut == 3'h3 && rxDataValid && rxSigOk && clkEn |=> fwdBlock && !dropBlock)
		else $error("good block not forwarded");
	a_drop_bad: assert property (
		modeOut == 3'h3 && rxDataValid && !rxSigOk && clkEn |=> dropBlock && !fwdBlock)
		else $error("bad block not dropped");
	a_tx_echo: assert property (
		modeOut == 3'h5 && serRxValid && clkEn |=> txCharValid && txChar == $past(serRxChar))
		else $error("serial char not packed");
	a_tx_only: assert property (txCharValid |-> $past(modeOut) == 3'h5)
		else $error("char packed outside transparent");
endmodule
bind modem_mode_ctrl modem_ctrl_checker u_modem_ctrl_checker (.clk, .resetn, .clkEn,
	.hreadyout, .hresp, .modem_enable_line, .rxSetupEnd, .rxDataValid, .rxSigOk,
	.serRxValid, .serRxChar, .ringLine, .fwdBlock, .dropBlock, .txCharValid, .txChar,
	.modeOut);
`default_nettype wire

//--- tb/datalogger_model.sv
// datalogger on the serial port: answers ring, holds telecom level
// assumes the bench's clock; hangUp ends a session
`default_nettype none
module datalogger_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ringLine,
	input wire logic telecomReq,
	input wire logic hangUp,
	output logic modem_enable_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic answered_r;
	logic [1:0] delay_r;
	// slow answer: a real logger needs time to wake
	always_ff @(posedge clk) begin
		if (!resetn || hangUp) begin
			answered_r <= '0;
			delay_r <= '0;
		end else if (ringLine && !answered_r) begin
			delay_r <= delay_r + 2'h1;
			answered_r <= delay_r == 2'h3;
		end
	end
	assign modem_enable_line = answered_r | telecomReq;
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the modem mode controller
// assumes the datalogger model and the bound port checker
`include "modem_cfg.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = '0, resetn = '0, hsel = '0, hwrite = '0, serRxValid = '0;
	logic [7:0] haddr = '0, serRxChar = '0, cmdChar, txChar, stationId;
	logic [1:0] htrans = '0;
	logic [31:0] hwdata = '0, hrdata, rd;
	logic [8:0] configSwitch = 9'h10a;
	logic radioCarrier = '0, rxNotForUs = '0, rxBlockValid = '0, rxSetupMid = '0;
	logic rxSetupEnd = '0, rxDataValid = '0, rxSigOk = '0, telecomReq = '0, hangUp = '0;
	logic clkEn = 1'h1, linkVerified = '0;
	logic hreadyout, hresp, ringLine, carrierLamp, fwdBlock, dropBlock, cmdValid;
	logic txCharValid, txBlockClose, modem_enable_line;
	logic [2:0] modeOut;
	int error_cnt = 0, tests_run = 0;
	// short tick keeps the minute timer inside the run
	modem_mode_ctrl #(.TICK_CYCLES(2)) u_modem_mode_ctrl (.clk, .resetn, .clkEn,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .configSwitch, .modem_enable_line, .radioCarrier,
		.ringLine, .carrierLamp, .rxNotForUs, .rxBlockValid, .rxSetupMid, .rxSetupEnd,
		.linkVerified, .rxDataValid, .rxSigOk, .fwdBlock, .dropBlock, .serRxValid,
		.serRxChar, .cmdValid, .cmdChar, .txCharValid, .txChar, .txBlockClose, .modeOut,
		.stationId);
	datalogger_model u_datalogger_model (.clk, .resetn, .ringLine, .telecomReq, .hangUp,
		.modem_enable_line);
	// ====
	// helpers
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= '0;
		htrans <= '0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd = hrdata;
		#1;
	endtask
	task automatic ser(input logic [7:0] c);
		@(posedge clk);
		serRxValid <= 1'h1;
		serRxChar <= c;
		@(posedge clk);
		serRxValid <= '0;
		#1;
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
		n = 0;
		while (modeOut !== m && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ====
	// scenarios
	task automatic t_local;
		int n;
		telecomReq <= 1'h1;
		cyc(10);
		chk("mode", 3'h2, modeOut);
		ser(8'h41);
		chk("cmd", 9'h141, {cmdValid, cmdChar});
		ser(8'h61);
		chk("lower cmd", 1'h0, cmdValid);
		telecomReq <= '0;
		cyc(10);
		bus(1'h1, `REG_CTRL, 32'h8);
		chk("bus term mode", 3'h1, modeOut);
		telecomReq <= 1'h1;
		cyc(10);
		chk("mode", 3'h2, modeOut);
		ser(`CMD_TERMINATE);
		chk("mode", 3'h1, modeOut);
		// telecom still high: wait falls straight back to local
		cyc(2);
		chk("mode", 3'h2, modeOut);
		@(posedge clk) linkVerified <= 1'h1;
		@(posedge clk) linkVerified <= '0;
		#1;
		chk("linked mode", 3'h5, modeOut);
		telecomReq <= '0;
		wait_mode(3'h1, 13000, n);
		chk("idle expiry", 3'h1, modeOut);
	endtask
	task automatic t_repeat;
		int n;
		@(posedge clk) rxSetupMid <= 1'h1;
		@(posedge clk) rxSetupMid <= '0;
		cyc(1);
		chk("mode", 3'h3, modeOut);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) rxDataValid <= 1'h1;
			rxSigOk <= i[0];
			@(posedge clk) rxDataValid <= '0;
			#1;
			chk("fwd drop", i ? 2'h2 : 2'h1, {fwdBlock, dropBlock});
		end
		// a block offered while the enable is low must leave no trace
		@(posedge clk) clkEn <= '0;
		rxDataValid <= 1'h1;
		rxSigOk <= 1'h1;
		@(posedge clk) rxDataValid <= '0;
		#1;
		chk("frozen fwd drop", 2'h0, {fwdBlock, dropBlock});
		chk("frozen mode", 3'h3, modeOut);
		@(posedge clk) clkEn <= 1'h1;
		cyc(8000);
		@(posedge clk) rxBlockValid <= 1'h1;
		@(posedge clk) rxBlockValid <= '0;
		wait_mode(3'h1, 14000, n);
		chk("expiry near 12000", 1'h1, n > 11900 && n < 12100);
	endtask
	task automatic t_end;
		int n;
		@(posedge clk) rxSetupEnd <= 1'h1;
		@(posedge clk) rxSetupEnd <= '0;
		cyc(1);
		chk("end ring", 4'hc, {ringLine, modeOut});
		wait_mode(3'h5, 20, n);
		chk("transparent ring", 4'h5, {ringLine, modeOut});
		bus(1'h0, `REG_STATUS, '0);
		chk("status", 32'h90a5, rd);
		for (int i = 1; i <= `BLOCK_CHARS; i++) begin
			ser(i[7:0]);
			chk("tx char", {1'h1, i[7:0]}, {txCharValid, txChar});
			chk("close", i == `BLOCK_CHARS, txBlockClose);
		end
		ser(8'h41);
		ser(8'h42);
		n = 0;
		while (txBlockClose !== 1'h1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk("gap close near 58", 1'h1, n > 54 && n < 62);
		cyc(13000);
		chk("held mode", 3'h5, modeOut);
		@(posedge clk) hangUp <= 1'h1;
		@(posedge clk) hangUp <= '0;
		wait_mode(3'h1, 13000, n);
		chk("mode", 3'h1, modeOut);
	endtask
	task automatic t_lamp;
		@(posedge clk) radioCarrier <= 1'h1;
		cyc(60);
		chk("lamp", 1'h1, carrierLamp);
		radioCarrier <= '0;
		cyc(10);
		chk("lamp", 1'h0, carrierLamp);
		radioCarrier <= 1'h1;
		cyc(10);
		rxNotForUs <= 1'h1;
		cyc(1);
		rxNotForUs <= '0;
		cyc(10);
		chk("lamp", 1'h1, carrierLamp);
		cyc(32);
		chk("lamp", 1'h0, carrierLamp);
		radioCarrier <= '0;
	endtask
	// samples fall mid-phase: 1 s is 200 cycles here
	task automatic flash(input logic [31:0] d, input int t[5], input logic [4:0] e);
		bus(1'h1, `REG_CTRL, d);
		for (int k = 0; k < 5; k++) begin
			cyc(t[k]);
			chk("flash lamp", e[k], carrierLamp);
		end
	endtask
	// ====
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'h1;
		cyc(20);
		chk("id", 8'h0a, stationId);
		bus(1'h0, `REG_CONFIG, '0);
		chk("config", 32'h10a, rd);
		bus(1'h0, 8'h0c, '0);
		chk("unmapped", 32'h0, rd);
		chk("mode", 3'h1, modeOut);
		t_local();
		t_repeat();
		t_end();
		t_lamp();
		flash(32'h1, '{100, 200, 200, 200, 400}, 5'h05);
		flash(32'h3, '{50, 100, 100, 100, 1100}, 5'h15);
		flash(32'h5, '{100, 150, 100, 100, 2150}, 5'h15);
		resetn <= '0;
		configSwitch <= 9'h000;
		cyc(8);
		resetn <= 1'h1;
		cyc(20);
		chk("shipped id", 8'h01, stationId);
		bus(1'h0, `REG_CONFIG, '0);
		chk("sync state config", 32'h001, rd);
		test_done();
	end
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
